// ### logic/p6_pkg.sv
package p6_pkg;

  // register indices; byte address is index times four
  localparam int          ADDR_W       = 20;
  localparam logic [17:0] IDX_DATA     = 18'h0f260;
  localparam logic [17:0] IDX_DIR      = 18'h0f261;
  localparam logic [17:0] IDX_CTL_LO   = 18'h0f262;
  localparam logic [17:0] IDX_CTL_HI   = 18'h0f263;
  localparam logic [17:0] IDX_FSEL_LO  = 18'h0f264;
  localparam logic [17:0] IDX_FSEL_HI  = 18'h0f265;
  localparam logic [1:0]  BYTE_LANE_OK = 2'h0;

  localparam logic [7:0]  RST_DATA     = 8'h00;
  localparam logic [7:0]  RST_DIR      = 8'h00;
  localparam logic [7:0]  RST_CTL      = 8'h00;
  localparam logic [7:0]  RST_FSEL     = 8'h00;
  localparam logic [7:0]  FSEL_WMASK   = 8'h73;

  localparam logic        DIR_OUT      = 1'h0;
  localparam logic        DIR_IN       = 1'h1;

  // output mode drive types
  localparam logic [1:0]  CTL_HIZ      = 2'h0;
  localparam logic [1:0]  CTL_PCH      = 2'h1;
  localparam logic [1:0]  CTL_NCH      = 2'h2;
  localparam logic [1:0]  CTL_CMOS     = 2'h3;
  // input mode conditions
  localparam logic [1:0]  CTL_PULL_DN  = 2'h1;
  localparam logic [1:0]  CTL_PULL_UP  = 2'h2;

  localparam logic [1:0]  FUNC_GPIO    = 2'h0;
  localparam logic [1:0]  FUNC_SEC     = 2'h1;
  localparam logic [1:0]  FUNC_TER     = 2'h2;
  localparam logic [1:0]  FUNC_QUA     = 2'h3;

  // legal function codes per pin, pin 7 first
  localparam logic [7:0][3:0] FUNC_LEGAL = {4'h1, 4'h7, 4'h7, 4'h5,
                                            4'h1, 4'h1, 4'hf, 4'hf};

  typedef struct packed {
    logic [7:0]  data;
    logic [7:0]  dir;
    logic [7:0]  ctl_lo;
    logic [7:0]  ctl_hi;
    logic [7:0]  fsel_lo;
    logic [7:0]  fsel_hi;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  pull_up;
    logic [7:0]  pull_down;
  } p6_state_type;

endpackage

// ### logic/p6_pin_drive.sv
`timescale 1ns/1ns
module p6_pin_drive (
  input  wire logic       dir,
  input  wire logic [1:0] ctl,
  input  wire logic [1:0] func,
  input  wire logic [3:0] src,
  input  wire logic [3:0] legal,
  output logic            oe,
  output logic            out,
  output logic            pull_up,
  output logic            pull_down
);

  logic level;
  logic unused_code;

  always_comb begin
    level       = src[func];
    unused_code = !legal[func];
    oe          = 1'b0;
    out         = 1'b0;
    pull_up     = 1'b0;
    pull_down   = 1'b0;
    if (dir == p6_pkg::DIR_OUT) begin
      case (ctl)
        p6_pkg::CTL_PCH: begin
          // unused code keeps p-channel released
          if (!unused_code && level) begin
            oe  = 1'b1;
            out = 1'b1;
          end
        end
        p6_pkg::CTL_NCH: begin
          if (unused_code || !level) begin
            oe = 1'b1;
          end
        end
        p6_pkg::CTL_CMOS: begin
          oe  = 1'b1;
          out = level && !unused_code;
        end
        default: begin
          oe = 1'b0;
        end
      endcase
    end else begin
      case (ctl)
        p6_pkg::CTL_PULL_DN: pull_down = 1'b1;
        p6_pkg::CTL_PULL_UP: pull_up = 1'b1;
        default:             pull_up = 1'b0;
      endcase
    end
  end

endmodule

// ### logic/p6_port.sv
// Register access over APB was decided locally.
`timescale 1ns/1ns
// Operation
// - function select low register at index 0f264, reset zero, bits 7,3,2 zero
// - function select high register at index 0f265, reset zero, bits 7,3,2 zero
// - pin 6: 00 gpio, 01 fast clock, 10 pwm six, 11 forbidden
// - pin 5: 00 gpio, 01 slow clock, 10 pwm five, 11 forbidden
// - pin 4: 00 gpio, 10 pwm four, 01 and 11 forbidden
// - pin 1: 00 gpio, 01 i2c clock, 10 timer b, 11 pwm seven
// - pin 0: 00 gpio, 01 i2c data, 10 timer a, 11 pwm six
// - unused code in output mode ignores data; hiz/pch float, nch/cmos low
// - each pin is output or input by its own direction bit
// - output mode drive: hiz, p-channel od, n-channel od or cmos per pin
// - input mode: hiz, pull-down or pull-up per pin, same control bits
// - reset leaves every pin in output mode with high-impedance drive
// - output mode drives the data register bit under select code 00, else the selected function, subject to drive type
// - input mode data read returns the sampled pin level
// - direction bit 0 is output, 1 is input, resets to output
// - control pair high:low selects drive or input condition
module p6_port (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [p6_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [7:0]                pin_in,
  output logic      [7:0]                pin_out,
  output logic      [7:0]                pin_oe,
  output logic      [7:0]                pin_pull_up,
  output logic      [7:0]                pin_pull_down,
  output logic      [7:0]                pin_level,
  input  wire logic                      fast_clock_out,
  input  wire logic                      slow_clock_out,
  input  wire logic                      pulse_width_out_four,
  input  wire logic                      pulse_width_out_five,
  input  wire logic                      pulse_width_out_six,
  input  wire logic                      pulse_width_out_seven,
  input  wire logic                      timer_a_output,
  input  wire logic                      timer_b_output,
  input  wire logic                      i2c_scl_out,
  input  wire logic                      i2c_sda_out
);

  p6_pkg::p6_state_type st;
  p6_pkg::p6_state_type next_st;

  logic [7:0][3:0] alt_src;
  logic [7:0]      drv_oe;
  logic [7:0]      drv_out;
  logic [7:0]      drv_pu;
  logic [7:0]      drv_pd;
  logic [17:0]     acc_idx;
  logic            acc_aligned;
  logic            setup_cyc;
  logic            wr_take;

  assign acc_idx     = paddr[p6_pkg::ADDR_W-1:2];
  assign acc_aligned = (paddr[1:0] == p6_pkg::BYTE_LANE_OK);
  assign setup_cyc   = psel && !penable;
  assign wr_take     = psel && penable && st.pready && pwrite &&
                       !st.pslverr && pstrb[0];

  // per-pin source table; entry 0 is always the data register bit
  always_comb begin
    alt_src = '0;
    for (int i = 0; i < 8; i++) begin
      alt_src[i][p6_pkg::FUNC_GPIO] = st.data[i];
    end
    alt_src[6][p6_pkg::FUNC_SEC] = fast_clock_out;
    alt_src[6][p6_pkg::FUNC_TER] = pulse_width_out_six;
    alt_src[5][p6_pkg::FUNC_SEC] = slow_clock_out;
    alt_src[5][p6_pkg::FUNC_TER] = pulse_width_out_five;
    alt_src[4][p6_pkg::FUNC_TER] = pulse_width_out_four;
    alt_src[1][p6_pkg::FUNC_SEC] = i2c_scl_out;
    alt_src[1][p6_pkg::FUNC_TER] = timer_b_output;
    alt_src[1][p6_pkg::FUNC_QUA] = pulse_width_out_seven;
    alt_src[0][p6_pkg::FUNC_SEC] = i2c_sda_out;
    alt_src[0][p6_pkg::FUNC_TER] = timer_a_output;
    alt_src[0][p6_pkg::FUNC_QUA] = pulse_width_out_six;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_pin
      p6_pin_drive u_drive (
        .dir       (st.dir[g]),
        .ctl       ({st.ctl_hi[g], st.ctl_lo[g]}),
        .func      ({st.fsel_hi[g], st.fsel_lo[g]}),
        .src       (alt_src[g]),
        .legal     (p6_pkg::FUNC_LEGAL[g]),
        .oe        (drv_oe[g]),
        .out       (drv_out[g]),
        .pull_up   (drv_pu[g]),
        .pull_down (drv_pd[g])
      );
    end
  endgenerate

  always_comb begin
    next_st         = st;
    // level pins pass two flops before anything reads them
    next_st.sync1   = pin_in;
    next_st.sync2   = st.sync1;
    // answer registered in setup so access sees pready at once
    next_st.pready  = setup_cyc;
    next_st.pslverr = 1'b0;
    next_st.prdata  = '0;
    if (setup_cyc) begin
      if (!acc_aligned) begin
        next_st.pslverr = 1'b1;
      end else begin
        case (acc_idx)
          p6_pkg::IDX_DATA: begin
            // output bits read back the latch, input bits the pin
            next_st.prdata[7:0] = (st.dir & st.sync2) |
                                  (~st.dir & st.data);
          end
          p6_pkg::IDX_DIR:     next_st.prdata[7:0] = st.dir;
          p6_pkg::IDX_CTL_LO:  next_st.prdata[7:0] = st.ctl_lo;
          p6_pkg::IDX_CTL_HI:  next_st.prdata[7:0] = st.ctl_hi;
          p6_pkg::IDX_FSEL_LO: next_st.prdata[7:0] = st.fsel_lo;
          p6_pkg::IDX_FSEL_HI: next_st.prdata[7:0] = st.fsel_hi;
          default:             next_st.pslverr = 1'b1;
        endcase
      end
    end
    if (wr_take) begin
      case (acc_idx)
        p6_pkg::IDX_DATA:    next_st.data = pwdata[7:0];
        p6_pkg::IDX_DIR:     next_st.dir = pwdata[7:0];
        p6_pkg::IDX_CTL_LO:  next_st.ctl_lo = pwdata[7:0];
        p6_pkg::IDX_CTL_HI:  next_st.ctl_hi = pwdata[7:0];
        p6_pkg::IDX_FSEL_LO: begin
          next_st.fsel_lo = pwdata[7:0] & p6_pkg::FSEL_WMASK;
        end
        p6_pkg::IDX_FSEL_HI: begin
          next_st.fsel_hi = pwdata[7:0] & p6_pkg::FSEL_WMASK;
        end
        default:             next_st.data = st.data;
      endcase
    end
    // pads retimed; a peripheral clock at pclk rate is not reproducible
    next_st.pin_oe    = drv_oe;
    next_st.pin_out   = drv_out;
    next_st.pull_up   = drv_pu;
    next_st.pull_down = drv_pd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.data      <= p6_pkg::RST_DATA;
      st.dir       <= p6_pkg::RST_DIR;
      st.ctl_lo    <= p6_pkg::RST_CTL;
      st.ctl_hi    <= p6_pkg::RST_CTL;
      st.fsel_lo   <= p6_pkg::RST_FSEL;
      st.fsel_hi   <= p6_pkg::RST_FSEL;
      st.sync1     <= '0;
      st.sync2     <= '0;
      st.pready    <= 1'b0;
      st.pslverr   <= 1'b0;
      st.prdata    <= '0;
      st.pin_out   <= '0;
      st.pin_oe    <= '0;
      st.pull_up   <= '0;
      st.pull_down <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign pin_out       = st.pin_out;
  assign pin_oe        = st.pin_oe;
  assign pin_pull_up   = st.pull_up;
  assign pin_pull_down = st.pull_down;
  assign pin_level     = st.sync2;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_fsel_reserved;
    ((st.fsel_lo | st.fsel_hi) & ~p6_pkg::FSEL_WMASK) == 8'h00;
  endproperty
  a_fsel_reserved: assert property (p_fsel_reserved)
    else $error("reserved function select bits not zero");

  property p_hiz_idle;
    1 |=> (st.pin_oe & ~$past(st.dir) &
           ~($past(st.ctl_lo) | $past(st.ctl_hi))) == 8'h00;
  endproperty
  a_hiz_idle: assert property (p_hiz_idle)
    else $error("pin driven while set to high impedance output");

  property p_input_quiet;
    1 |=> (st.pin_oe & $past(st.dir)) == 8'h00;
  endproperty
  a_input_quiet: assert property (p_input_quiet)
    else $error("pin driven while in input mode");

  property p_cmos_gpio;
    (st.dir[0] == p6_pkg::DIR_OUT && st.ctl_hi[0] && st.ctl_lo[0] &&
     !st.fsel_hi[0] && !st.fsel_lo[0])
      |=> st.pin_oe[0] && (st.pin_out[0] == $past(st.data[0]));
  endproperty
  a_cmos_gpio: assert property (p_cmos_gpio)
    else $error("cmos pin 0 does not follow data bit");

  property p_unused_nch;
    (st.dir[4] == p6_pkg::DIR_OUT && st.ctl_hi[4] && !st.ctl_lo[4] &&
     st.fsel_lo[4])
      |=> st.pin_oe[4] && !st.pin_out[4];
  endproperty
  a_unused_nch: assert property (p_unused_nch)
    else $error("unused code on pin 4 not held low");

  property p_pch_drive;
    (st.dir[2] == p6_pkg::DIR_OUT && !st.ctl_hi[2] && st.ctl_lo[2])
      |=> (st.pin_oe[2] == $past(st.data[2])) && 
          (st.pin_out[2] == $past(st.data[2]));
  endproperty
  a_pch_drive: assert property (p_pch_drive)
    else $error("p-channel open drain wrong on pin 2");

  property p_pull_up;
    (st.dir[3] == p6_pkg::DIR_IN && st.ctl_hi[3] && !st.ctl_lo[3])
      |=> st.pull_up[3] && !st.pull_down[3];
  endproperty
  a_pull_up: assert property (p_pull_up)
    else $error("pull-up not applied on input pin 3");

  property p_fast_clock;
    (st.dir[6] == p6_pkg::DIR_OUT && st.ctl_hi[6] && st.ctl_lo[6] &&
     !st.fsel_hi[6] && st.fsel_lo[6])
      |=> st.pin_out[6] == $past(fast_clock_out);
  endproperty
  a_fast_clock: assert property (p_fast_clock)
    else $error("pin 6 does not carry the fast clock");

  property p_read_input;
    (setup_cyc && !pwrite && acc_aligned &&
     acc_idx == p6_pkg::IDX_DATA && st.dir == 8'hff)
      |=> st.pready && st.prdata[7:0] == $past(st.sync2);
  endproperty
  a_read_input: assert property (p_read_input)
    else $error("data read does not return pin level");

  property p_fsel_write;
    (wr_take && acc_idx == p6_pkg::IDX_FSEL_LO)
      |=> st.fsel_lo == ($past(pwdata[7:0]) & p6_pkg::FSEL_WMASK);
  endproperty
  a_fsel_write: assert property (p_fsel_write)
    else $error("function select low write lost");

  property p_dir_write;
    (wr_take && acc_idx == p6_pkg::IDX_DIR)
      |=> st.dir == $past(pwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write lost");

  property p_nch_drive;
    (st.dir[3] == p6_pkg::DIR_OUT && st.ctl_hi[3] && !st.ctl_lo[3])
      |=> (st.pin_oe[3] == !$past(st.data[3])) && !st.pin_out[3];
  endproperty
  a_nch_drive: assert property (p_nch_drive)
    else $error("n-channel open drain wrong on pin 3");

  property p_pull_down;
    (st.dir[5] == p6_pkg::DIR_IN && !st.ctl_hi[5] && st.ctl_lo[5])
      |=> st.pull_down[5] && !st.pull_up[5] && !st.pin_oe[5];
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("pull-down not applied on input pin 5");

  property p_input_hiz;
    (st.dir[7] == p6_pkg::DIR_IN && st.ctl_hi[7] && st.ctl_lo[7])
      |=> !st.pull_up[7] && !st.pull_down[7];
  endproperty
  a_input_hiz: assert property (p_input_hiz)
    else $error("pull applied on high impedance input pin 7");

  property p_output_no_pull;
    1 |=> ((st.pull_up | st.pull_down) & ~$past(st.dir)) == 8'h00;
  endproperty
  a_output_no_pull: assert property (p_output_no_pull)
    else $error("pull resistor enabled on an output pin");

  property p_slow_clock;
    (st.dir[5] == p6_pkg::DIR_OUT && st.ctl_hi[5] && st.ctl_lo[5] &&
     !st.fsel_hi[5] && st.fsel_lo[5])
      |=> st.pin_out[5] == $past(slow_clock_out);
  endproperty
  a_slow_clock: assert property (p_slow_clock)
    else $error("pin 5 does not carry the slow clock");

  property p_pwm_four;
    (st.dir[4] == p6_pkg::DIR_OUT && st.ctl_hi[4] && st.ctl_lo[4] &&
     st.fsel_hi[4] && !st.fsel_lo[4])
      |=> st.pin_out[4] == $past(pulse_width_out_four);
  endproperty
  a_pwm_four: assert property (p_pwm_four)
    else $error("pin 4 does not carry pulse width four");

  property p_pin1_quartic;
    (st.dir[1] == p6_pkg::DIR_OUT && st.ctl_hi[1] && st.ctl_lo[1] &&
     st.fsel_hi[1] && st.fsel_lo[1])
      |=> st.pin_out[1] == $past(pulse_width_out_seven);
  endproperty
  a_pin1_quartic: assert property (p_pin1_quartic)
    else $error("pin 1 does not carry pulse width seven");

  property p_pin0_timer;
    (st.dir[0] == p6_pkg::DIR_OUT && st.ctl_hi[0] && st.ctl_lo[0] &&
     st.fsel_hi[0] && !st.fsel_lo[0])
      |=> st.pin_out[0] == $past(timer_a_output);
  endproperty
  a_pin0_timer: assert property (p_pin0_timer)
    else $error("pin 0 does not carry timer a output");

  property p_unused_pch;
    (st.dir[6] == p6_pkg::DIR_OUT && !st.ctl_hi[6] && st.ctl_lo[6] &&
     st.fsel_hi[6] && st.fsel_lo[6])
      |=> !st.pin_oe[6];
  endproperty
  a_unused_pch: assert property (p_unused_pch)
    else $error("unused code on pin 6 not released");

  property p_ready_pulse;
    setup_cyc |=> st.pready ##1 !st.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready is not a single cycle answer");

  c_fsel_write: cover property (wr_take && acc_idx == p6_pkg::IDX_FSEL_HI);
  c_input_read: cover property (setup_cyc && !pwrite && st.dir != 8'h00);
  c_cmos_high:  cover property (st.pin_oe[0] && st.pin_out[0]);
  c_pull_down:  cover property (st.pull_down != 8'h00);
  c_bad_addr:   cover property (st.pready && st.pslverr);

endmodule

// ### verif/p6_board.sv
`timescale 1ns/1ns
module p6_board (
  input  wire logic       pclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull_up,
  input  wire logic [7:0] pin_pull_down,
  input  wire logic [7:0] ext_drv,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_wire
);
  // undriven pads wander, so a stale level never reads as valid
  logic [7:0] flt = 8'h55;

  always @(posedge pclk) flt <= ~flt;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_wire[i] = pin_out[i];
      else if (ext_drv[i]) pin_wire[i] = ext_val[i];
      else if (pin_pull_up[i]) pin_wire[i] = 1'h1;
      else if (pin_pull_down[i]) pin_wire[i] = 1'h0;
      else pin_wire[i] = flt[i];
    end
  end
endmodule

// ### verif/port6_io_and_function_mux_bench.sv
`timescale 1ns/1ns
module port6_io_and_function_mux_bench;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pin_wire, pin_out, pin_oe, pu, pd, lvl;
  logic [7:0]  ext_drv = 8'h0;
  logic [7:0]  ext_val = 8'h0;
  logic [9:0]  per = 10'h0;
  int          r[6];
  int          num_errors = 0;
  int          checks = 0;

  always #50 pclk = ~pclk;

  p6_port p6_port_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .pin_in(pin_wire),
    .pin_out, .pin_oe, .pin_pull_up(pu), .pin_pull_down(pd),
    .pin_level(lvl), .fast_clock_out(per[0]), .slow_clock_out(per[1]),
    .pulse_width_out_four(per[2]), .pulse_width_out_five(per[3]),
    .pulse_width_out_six(per[4]), .pulse_width_out_seven(per[5]),
    .timer_a_output(per[6]), .timer_b_output(per[7]),
    .i2c_scl_out(per[8]), .i2c_sda_out(per[9]));

  p6_board p6_board_i (.pclk, .pin_out, .pin_oe, .pin_pull_up(pu),
    .pin_pull_down(pd), .ext_drv, .ext_val, .pin_wire);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] g, e, m, input string s);
    checks++;
    if ((g & m) !== (e & m)) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask

  function automatic logic [19:0] ad(int j);
    return {p6_pkg::IDX_DATA + 18'(j), 2'h0};
  endfunction

  // request held until the rising edge that samples pready high
  task automatic apb(input logic w, input logic [19:0] a,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output logic er);
    int n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) begin
      num_errors++;
      stop_test();
    end else begin
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task automatic wr(int j, int v);
    logic [7:0] rd;
    logic       er;
    apb(1'h1, ad(j), 8'(v), rd, er);
    r[j] = j >= 4 ? v & 32'h73 : v & 32'hff;
    cmp({7'h0, er}, 8'h0, 8'hff, "write error");
  endtask

  task automatic rdc(int j, logic [7:0] e);
    logic [7:0] rd;
    logic       er;
    apb(1'h0, ad(j), 8'h0, rd, er);
    cmp(rd, e, 8'hff, "register read");
  endtask

  // pin level for a select code, 2 when the code is unused
  function automatic int plev(int i, int c);
    if (c == 0) return r[0] >> i & 1;
    case (i * 4 + c)
      25: return int'(per[0]);
      21: return int'(per[1]);
      18: return int'(per[2]);
      22: return int'(per[3]);
      26, 3: return int'(per[4]);
      7: return int'(per[5]);
      2: return int'(per[6]);
      6: return int'(per[7]);
      5: return int'(per[8]);
      1: return int'(per[9]);
      default: return 2;
    endcase
  endfunction

  task automatic check_pins();
    logic [7:0] eo, ev, eu, ed, xd, xm, rd, el, em;
    logic       er;
    int         c, k, l;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    for (int i = 0; i < 8; i++) begin
      c = (r[5] >> i & 1) * 2 + (r[4] >> i & 1);
      k = (r[3] >> i & 1) * 2 + (r[2] >> i & 1);
      l = plev(i, c);
      {eo[i], ev[i], eu[i], ed[i], xm[i]} = 5'h1;
      xd[i] = r[0][i];
      if (r[1][i]) begin
        eu[i] = k == 2;
        ed[i] = k == 1;
        xd[i] = ext_drv[i] ? ext_val[i] : k == 2;
        xm[i] = ext_drv[i] || k inside {1, 2};
      end else if (l == 2) begin
        eo[i] = k >= 2;
      end else begin
        eo[i] = k == 3 || (k == 1 && l == 1) || (k == 2 && l == 0);
        ev[i] = k != 2 && l == 1;
      end
      // floating pads wander, so only driven or pulled pins are checked
      em[i] = eo[i] || ext_drv[i] || eu[i] || ed[i];
      el[i] = eo[i] ? ev[i] : ext_drv[i] ? ext_val[i] : eu[i];
    end
    cmp(pin_oe, eo, 8'hff, "output enable");
    cmp(pin_out, ev, eo, "pin level");
    cmp(pu, eu, 8'hff, "pull up");
    cmp(pd, ed, 8'hff, "pull down");
    cmp(lvl, el, em, "synchronised level");
    apb(1'h0, ad(0), 8'h0, rd, er);
    cmp(rd, xd, xm, "data read");
  endtask

  initial begin
    logic [7:0] rd;
    logic       er;
    void'($urandom(81525));
    for (int j = 0; j < 6; j++) r[j] = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (int j = 0; j < 6; j++) rdc(j, 8'h0);
    check_pins();
    $display("test reset done");
    wr(4, 255);
    wr(5, 255);
    rdc(4, 8'h73);
    rdc(5, 8'h73);
    $display("test select mask done");
    apb(1'h0, 20'h3c998, 8'h0, rd, er);
    cmp({er, rd[6:0]}, 8'h80, 8'hff, "unmapped read");
    apb(1'h1, 20'h3c991, 8'h0, rd, er);
    cmp({7'h0, er}, 8'h1, 8'hff, "unaligned write");
    rdc(4, 8'h73);
    $display("test refusal done");
    ext_drv <= 8'hff;
    ext_val <= 8'h5a;
    wr(1, 255);
    check_pins();
    $display("test input read done");
    for (int t = 0; t < 60; t++) begin
      per <= 10'($urandom);
      ext_drv <= 8'($urandom);
      ext_val <= 8'($urandom);
      for (int j = 0; j < 6; j++) wr(j, $urandom & 32'hff);
      check_pins();
    end
    $display("test random pins done");
    @(posedge pclk);
    presetn <= 1'h0;
    for (int j = 0; j < 6; j++) r[j] = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (int j = 0; j < 6; j++) rdc(j, 8'h0);
    check_pins();
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
